// file: include/mcfe_cfg.svh
// constants of the memory clock fan-out enable block
`ifndef MCFE_CFG_SVH
`define MCFE_CFG_SVH

`define MCFE_NUM_OUT      10
`define MCFE_EN_RST       10'h03ff
`define MCFE_DEV_ADDR     7'h69
`define MCFE_DIR_WRITE    1'h0
`define MCFE_LAST_BIT     3'h7
`define MCFE_CNT_ONE      3'h1
`define MCFE_CNT_ZERO     3'h0

`define MCFE_BYTE_LOW     2'h0
`define MCFE_BYTE_MID     2'h1
`define MCFE_BYTE_FB      2'h2
`define MCFE_BYTE_NONE    2'h3
`define MCFE_BYTE_STEP    2'h1

`define MCFE_LOW_HI       3
`define MCFE_LOW_LO       0
`define MCFE_MID_HI       7
`define MCFE_MID_LO       4
`define MCFE_FB9_SRC      7
`define MCFE_FB8_SRC      6
`define MCFE_FB9_OUT      9
`define MCFE_FB8_OUT      8

`endif

// file: include/mcfe_pkg.sv
// types of the memory clock fan-out enable block
package mcfe_pkg;

	typedef enum logic [1:0] {
		MCFE_IDLE = 2'h0,
		MCFE_ADDR = 2'h1,
		MCFE_ACK  = 2'h3,
		MCFE_DATA = 2'h2
	} mcfe_link_state_type;

endpackage

// file: src/mcfe_clk_gate.sv
// glitch-free enable gate for one buffered clock output
`timescale 1ns/10ps

module mcfe_clk_gate (
	// buffered clock domain
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	// enable from the control domain
	input  wire logic en_in,
	// gated clock
	output logic      clk_out
);

	logic en_s1_q;
	logic en_s2_q;
	logic en_gate_q;

	// power-up value is enabled, so clocks run before any write
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_s1_q <= 1'h1;
			en_s2_q <= 1'h1;
		end else begin
			en_s1_q <= en_in;
			en_s2_q <= en_s1_q;
		end
	end

	// change only while the clock is low: no runt pulses
	always_ff @(negedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_gate_q <= 1'h1;
		end else begin
			en_gate_q <= en_s2_q;
		end
	end

	// disabled output rests low, still driven
	assign clk_out = ref_clk_in & en_gate_q;

endmodule

// file: src/mcfe_top.sv
// memory clock fan-out buffer with serial output-enable port
`timescale 1ns/10ps
`include "mcfe_cfg.svh"

// Summary of operation
// R1: Ten outputs repeat the input clock while drive pin high and enabled.
// R2: Drive pin low puts every buffered clock output in high impedance.
// R3: The serial port switches each buffered output on or off individually.
// R4: After power-up every output is enabled before any serial write.
// R5: Bytes go byte zero upward, each sent bit seven first.
// R6: Host writes zero into every reserved or unused configuration bit.
// R7: Device answers serial address 1101001, A6 first, then direction bit.
// R8: First byte bits three to zero enable outputs three to zero.
// R9: Second byte bits seven to four enable outputs seven to four.
// R10: Third byte bit seven enables output nine, bit six output eight.
// R11: Enable bit one turns output on, zero off; default on.
// R12: A disabled output is driven static low while drive pin high.
// R13: Drive pin low overrides enables and leaves stored enables untouched.
module mcfe_top #(
	parameter int NUM_OUT = `MCFE_NUM_OUT
) (
	// control clock and reset
	input  wire logic               clk_in,
	input  wire logic               rst_n_in,
	// clock to be buffered
	input  wire logic               ref_clk_in,
	// output-drive pin
	input  wire logic               output_drive_in,
	// serial configuration port
	input  wire logic               serial_clock_in,
	input  wire logic               serial_data_pin_in,
	output logic                    serial_data_pin_out,
	output logic                    serial_data_pin_oe_n_out,
	// buffered clock outputs
	output logic [NUM_OUT-1:0]      bufclk_out,
	output logic [NUM_OUT-1:0]      bufclk_oe_n_out,
	// status
	output logic [NUM_OUT-1:0]      enables_out,
	output logic                    link_busy_out
);

	// reset release
	logic                           rst_s1_q;
	logic                           rst_n_q;

	// frame edge toggles
	logic                           start_tgl_q;
	logic                           stop_tgl_q;

	// serial clock domain
	mcfe_pkg::mcfe_link_state_type  state_q;
	mcfe_pkg::mcfe_link_state_type  state_d;
	mcfe_pkg::mcfe_link_state_type  cur_state;
	logic [2:0]                     bit_cnt_q;
	logic [2:0]                     bit_cnt_d;
	logic [2:0]                     cur_cnt;
	logic [7:0]                     shift_q;
	logic [7:0]                     shift_d;
	logic [1:0]                     byte_idx_q;
	logic [1:0]                     byte_idx_d;
	logic [1:0]                     cur_idx;
	logic [NUM_OUT-1:0]             shadow_q;
	logic [NUM_OUT-1:0]             shadow_d;
	logic                           upd_tgl_q;
	logic                           upd_tgl_d;
	logic                           start_seen_q;
	logic                           stop_seen_q;
	logic                           ack_drive_q;

	// control clock domain
	logic                           upd_s1_q;
	logic                           upd_s2_q;
	logic                           upd_s3_q;
	logic                           oe_s1_q;
	logic                           oe_s2_q;
	logic                           busy_s1_q;
	logic                           busy_s2_q;
	logic                           pend_q;
	logic                           pend_d;
	logic [NUM_OUT-1:0]             staged_q;
	logic [NUM_OUT-1:0]             enables_q;
	logic [NUM_OUT-1:0]             enables_d;
	logic [NUM_OUT-1:0]             oe_n_q;

	// decode wires
	wire                            start_evt;
	wire                            stop_evt;
	wire                            last_bit;
	wire                            addr_hit;
	wire                            byte_ok;
	wire                            link_busy;
	wire                            upd_evt;
	wire                            commit;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'h0;
			rst_n_q  <= 1'h0;
		end else begin
			rst_s1_q <= 1'h1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// start: data falls while serial clock high
	always_ff @(negedge serial_data_pin_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			start_tgl_q <= 1'h0;
		end else if (serial_clock_in) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	// stop: data rises while serial clock high
	always_ff @(posedge serial_data_pin_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			stop_tgl_q <= 1'h0;
		end else if (serial_clock_in) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	// toggles are long settled by the first rising serial clock of a frame
	assign start_evt = start_tgl_q != start_seen_q;
	assign stop_evt  = stop_tgl_q != stop_seen_q;

	// a start beats a stop seen at the same edge (repeated frames)
	assign cur_state = start_evt ? mcfe_pkg::MCFE_ADDR :
	                   stop_evt  ? mcfe_pkg::MCFE_IDLE : state_q;
	assign cur_cnt   = start_evt ? `MCFE_CNT_ZERO : bit_cnt_q;
	assign cur_idx   = start_evt ? `MCFE_BYTE_LOW : byte_idx_q;

	assign shift_d   = {shift_q[6:0], serial_data_pin_in}; // R5
	assign last_bit  = cur_cnt == `MCFE_LAST_BIT;
	assign addr_hit  = (shift_d[7:1] == `MCFE_DEV_ADDR) &&
	                   (shift_d[0] == `MCFE_DIR_WRITE); // R7
	assign byte_ok   = cur_idx != `MCFE_BYTE_NONE;

	always_comb begin
		state_d    = cur_state;
		bit_cnt_d  = cur_cnt;
		byte_idx_d = cur_idx;
		shadow_d   = shadow_q;
		upd_tgl_d  = upd_tgl_q;
		unique case (cur_state)
			mcfe_pkg::MCFE_IDLE: begin
				bit_cnt_d = `MCFE_CNT_ZERO;
			end
			mcfe_pkg::MCFE_ADDR: begin
				bit_cnt_d = cur_cnt + `MCFE_CNT_ONE;
				if (last_bit) begin
					// reads are refused: the port is write-only
					state_d = addr_hit ? mcfe_pkg::MCFE_ACK : mcfe_pkg::MCFE_IDLE; // R7
				end
			end
			mcfe_pkg::MCFE_ACK: begin
				state_d   = mcfe_pkg::MCFE_DATA;
				bit_cnt_d = `MCFE_CNT_ZERO;
			end
			mcfe_pkg::MCFE_DATA: begin
				bit_cnt_d = cur_cnt + `MCFE_CNT_ONE;
				if (last_bit) begin
					state_d = mcfe_pkg::MCFE_ACK;
					if (byte_ok) begin
						byte_idx_d = cur_idx + `MCFE_BYTE_STEP; // R5
						upd_tgl_d  = ~upd_tgl_q;
					end
					// reserved bits are dropped, whatever the host sent
					unique case (cur_idx)
						`MCFE_BYTE_LOW: begin
							shadow_d[`MCFE_LOW_HI:`MCFE_LOW_LO] =
								shift_d[`MCFE_LOW_HI:`MCFE_LOW_LO]; // R8
						end
						`MCFE_BYTE_MID: begin
							shadow_d[`MCFE_MID_HI:`MCFE_MID_LO] =
								shift_d[`MCFE_MID_HI:`MCFE_MID_LO]; // R9
						end
						`MCFE_BYTE_FB: begin
							shadow_d[`MCFE_FB9_OUT] = shift_d[`MCFE_FB9_SRC]; // R10
							shadow_d[`MCFE_FB8_OUT] = shift_d[`MCFE_FB8_SRC]; // R10
						end
						`MCFE_BYTE_NONE: begin
							shadow_d = shadow_q;
						end
					endcase
				end
			end
		endcase
	end

	// serial clock may stop between frames; nothing here waits on it
	always_ff @(posedge serial_clock_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q      <= mcfe_pkg::MCFE_IDLE;
			bit_cnt_q    <= `MCFE_CNT_ZERO;
			shift_q      <= 8'h00;
			byte_idx_q   <= `MCFE_BYTE_LOW;
			shadow_q     <= `MCFE_EN_RST; // R4
			upd_tgl_q    <= 1'h0;
			start_seen_q <= 1'h0;
			stop_seen_q  <= 1'h0;
		end else begin
			state_q      <= state_d;
			bit_cnt_q    <= bit_cnt_d;
			shift_q      <= shift_d;
			byte_idx_q   <= byte_idx_d;
			shadow_q     <= shadow_d; // R3
			upd_tgl_q    <= upd_tgl_d;
			start_seen_q <= start_tgl_q;
			stop_seen_q  <= stop_tgl_q;
		end
	end

	// acknowledge held from the falling edge after bit 8 to the one after bit 9
	always_ff @(negedge serial_clock_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ack_drive_q <= 1'h0;
		end else begin
			ack_drive_q <= state_q == mcfe_pkg::MCFE_ACK;
		end
	end

	assign serial_data_pin_out      = 1'h0;
	assign serial_data_pin_oe_n_out = ~ack_drive_q;
	// the serial clock stands still after a stop, so the stop itself ends the frame
	assign link_busy                = (state_q != mcfe_pkg::MCFE_IDLE) && !stop_evt;

	// control domain: toggle handshake carries each of the first three data bytes of a frame
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			upd_s1_q  <= 1'h0;
			upd_s2_q  <= 1'h0;
			upd_s3_q  <= 1'h0;
			oe_s1_q   <= 1'h1;
			oe_s2_q   <= 1'h1;
			busy_s1_q <= 1'h0;
			busy_s2_q <= 1'h0;
		end else begin
			upd_s1_q  <= upd_tgl_q;
			upd_s2_q  <= upd_s1_q;
			upd_s3_q  <= upd_s2_q;
			oe_s1_q   <= output_drive_in;
			oe_s2_q   <= oe_s1_q;
			busy_s1_q <= link_busy;
			busy_s2_q <= busy_s1_q;
		end
	end

	assign upd_evt = upd_s2_q ^ upd_s3_q;
	// writes made while the drive pin is low wait for it to return high
	assign commit  = pend_q & oe_s2_q; // R13
	// a new byte in the commit cycle keeps the pending flag set
	assign pend_d  = upd_evt | (pend_q & ~oe_s2_q);
	assign enables_d = commit ? staged_q : enables_q; // R11

	// shadow bus is stable: it changes at most once per serial byte
	always_ff @(posedge clk_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pend_q    <= 1'h0;
			staged_q  <= `MCFE_EN_RST;
			enables_q <= `MCFE_EN_RST; // R4
			oe_n_q    <= '0;
		end else begin
			pend_q    <= pend_d;
			staged_q  <= upd_evt ? shadow_q : staged_q;
			enables_q <= enables_d; // R13
			oe_n_q    <= {NUM_OUT{~oe_s2_q}}; // R2
		end
	end

	// one gate per output; disabled outputs stay driven low
	for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
		mcfe_clk_gate u_gate (
			.ref_clk_in (ref_clk_in),
			.rst_n_in   (rst_n_q),
			.en_in      (enables_q[i]), // R12
			.clk_out    (bufclk_out[i]) // R1
		);
	end

	assign bufclk_oe_n_out = oe_n_q; // R2
	assign enables_out     = enables_q;
	assign link_busy_out   = busy_s2_q;

endmodule

// file: dv/mcfe_host_model.sv
// serial host writing enable bytes to the fan-out block
`timescale 1ns/10ps
module mcfe_host_model (
	// serial wires
	output logic      scl_out,
	output logic      low_out,
	input  wire logic sda_in
);
	realtime hp = 3.0;
	initial begin
		scl_out = 1'b1;
		low_out = 1'b0;
	end
	// clock stands high outside frames, data released to pull-up
	task automatic send(input logic [31:0] fr, input int n, output logic nk);
		int k;
		int i;
		nk = 1'b0;
		low_out = 1'b1;
		#(hp);
		for (k = 0; k < n; k++) begin
			for (i = 7; i >= -1; i--) begin
				scl_out = 1'b0;
				#(hp / 2);
				low_out = (i >= 0) ? ~fr[24 - 8 * k + i] : 1'b0;
				#(hp / 2);
				scl_out = 1'b1;
				if (i < 0)
					nk = nk | sda_in;
				#(hp);
			end
		end
		scl_out = 1'b0;
		#(hp / 2);
		low_out = 1'b1;
		#(hp / 2);
		scl_out = 1'b1;
		#(hp / 2);
		low_out = 1'b0;
		#(hp);
	endtask
endmodule

// file: dv/mcfe_top_assertions.sv
// concurrent checks on the fan-out block ports
`timescale 1ns/10ps
module mcfe_top_assertions #(
	parameter int NUM_OUT = 10
) (
	input wire logic               clk_in,
	input wire logic               rst_n_in,
	input wire logic               ref_clk_in,
	input wire logic               output_drive_in,
	input wire logic               serial_clock_in,
	input wire logic               serial_data_pin_in,
	input wire logic               serial_data_pin_out,
	input wire logic               serial_data_pin_oe_n_out,
	input wire logic [NUM_OUT-1:0] bufclk_out,
	input wire logic [NUM_OUT-1:0] bufclk_oe_n_out,
	input wire logic [NUM_OUT-1:0] enables_out,
	input wire logic               link_busy_out
);
	AST_DRV_LOW_TRI: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!output_drive_in [*4] |-> &bufclk_oe_n_out) else $error("outputs not tristated");
	AST_DRV_HIGH_ON: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		output_drive_in [*4] |-> bufclk_oe_n_out == '0) else $error("outputs not driven");
	AST_EN_KEPT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!output_drive_in [*4] |=> $stable(enables_out)) else $error("enables moved");
	AST_EN_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!link_busy_out && output_drive_in) [*8] |-> $stable(enables_out))
		else $error("enables moved without frame");
	AST_DIS_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(bufclk_out & ~enables_out & ~$past(enables_out, 8)) == '0)
		else $error("disabled output toggles");
	AST_ACK_ONE: assert property (@(negedge serial_clock_in) disable iff (!rst_n_in)
		$fell(serial_data_pin_oe_n_out) |=> $rose(serial_data_pin_oe_n_out))
		else $error("ack not one period");
	AST_PIN_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		serial_data_pin_out == 1'b0) else $error("data pin drives high");
	AST_ACK_BUSY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(serial_data_pin_oe_n_out) |-> ##[1:6] link_busy_out)
		else $error("ack outside frame");
endmodule
bind mcfe_top mcfe_top_assertions #(.NUM_OUT(NUM_OUT)) chk_u (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .ref_clk_in(ref_clk_in),
	.output_drive_in(output_drive_in), .serial_clock_in(serial_clock_in),
	.serial_data_pin_in(serial_data_pin_in), .serial_data_pin_out(serial_data_pin_out),
	.serial_data_pin_oe_n_out(serial_data_pin_oe_n_out), .bufclk_out(bufclk_out),
	.bufclk_oe_n_out(bufclk_oe_n_out), .enables_out(enables_out),
	.link_busy_out(link_busy_out));

// file: dv/mcfe_top_tb.sv
// self-checking bench for the fan-out block
`timescale 1ns/10ps
module mcfe_top_tb;
	typedef struct packed {
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [9:0] en;
	} mcfe_row_type;
	// zeros in reserved bits, except row 2 which checks they are ignored
	mcfe_row_type rows [4] = '{
		'{8'h0f, 8'hf0, 8'hc0, 10'h3ff},
		'{8'h05, 8'h50, 8'h80, 10'h255},
		'{8'hfa, 8'haf, 8'h7f, 10'h1aa},
		'{8'h00, 8'h00, 8'h00, 10'h000}};
	logic       clk_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       ref_clk = 1'b0;
	logic       drive = 1'b1;
	logic       scl;
	logic       host_low;
	logic       sda;
	logic       nak;
	logic       pin_o;
	logic       pin_oe_n;
	logic       busy;
	logic [9:0] bufclk;
	logic [9:0] oe_n;
	logic [9:0] en;
	logic [9:0] acc_or;
	logic [9:0] acc_and;
	int         n_mismatch = 0;
	int         compares = 0;
	always #4 clk_in = ~clk_in;
	always #5 ref_clk = ~ref_clk;
	// open-drain wire with pull-up
	assign sda = (pin_oe_n | pin_o) & ~host_low;
	mcfe_host_model host_u (.scl_out(scl), .low_out(host_low), .sda_in(sda));
	mcfe_top dut_u (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .ref_clk_in(ref_clk),
		.output_drive_in(drive), .serial_clock_in(scl), .serial_data_pin_in(sda),
		.serial_data_pin_out(pin_o), .serial_data_pin_oe_n_out(pin_oe_n),
		.bufclk_out(bufclk), .bufclk_oe_n_out(oe_n), .enables_out(en),
		.link_busy_out(busy));
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] fr, input int n, input logic [9:0] e, input logic k);
		host_u.send(fr, n, nak);
		repeat (12) @(negedge clk_in);
		chk(en, e);
		chk({9'h000, nak}, {9'h000, k});
		chk({9'h000, busy}, 10'h000);
	endtask
	task automatic scan(input logic [9:0] e);
		acc_or = 10'h000;
		acc_and = 10'h3ff;
		repeat (20) begin
			@(negedge clk_in);
			acc_or = acc_or | bufclk;
			acc_and = acc_and & bufclk;
		end
		chk(acc_or, e);
		chk(acc_and, 10'h000);
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (4) @(negedge clk_in);
		chk(en, 10'h3ff);
		rst_n_in = 1'b1;
		repeat (5) @(negedge clk_in);
		chk(oe_n, 10'h000);
		scan(10'h3ff);
		for (int r = 0; r < 4; r++) begin
			wr({8'hd2, rows[r].b0, rows[r].b1, rows[r].b2}, 4, rows[r].en, 1'b0);
			scan(rows[r].en);
			$display("row %0d done", r);
		end
		wr({8'hd4, 24'hff_ffff}, 4, 10'h000, 1'b1);
		wr({8'hd3, 24'hff_ffff}, 4, 10'h000, 1'b1);
		wr({8'hd2, 8'h0f, 16'h0000}, 2, 10'h00f, 1'b0);
		$display("refusal and short frame done");
		host_u.hp = 12.0;
		wr({8'hd2, 8'h00, 8'hf0, 8'h40}, 4, 10'h1f0, 1'b0);
		host_u.hp = 3.0;
		$display("slow host done");
		drive = 1'b0;
		repeat (5) @(negedge clk_in);
		chk(oe_n, 10'h3ff);
		wr({8'hd2, 8'h05, 8'h50, 8'h80}, 4, 10'h1f0, 1'b0);
		drive = 1'b1;
		repeat (8) @(negedge clk_in);
		chk(en, 10'h255);
		chk(oe_n, 10'h000);
		$display("drive pin done");
		rst_n_in = 1'b0;
		repeat (4) @(negedge clk_in);
		chk(en, 10'h3ff);
		rst_n_in = 1'b1;
		repeat (5) @(negedge clk_in);
		chk(en, 10'h3ff);
		chk(oe_n, 10'h000);
		wr({8'hd2, 8'h0a, 8'h00, 8'h00}, 4, 10'h00a, 1'b0);
		$display("second reset done");
		end_sim();
	end
endmodule
